/* design/stack_exec.sv */
// Purpose: execute push, pop, returns and compute operand address
// Assumes: software issues one opcode per write to the instr register
// Notes: each instruction completes in one bus-visible step
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module stack_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic [7:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic w_have;
    logic b_pend;
    logic [1:0] b_code;
    logic [31:0] r_data;
    logic r_pend;
    logic [1:0] r_code;
    logic ext_en;
    logic [11:0] ptr_two;
    logic in_high;
    logic [20:0] pc;
    logic [7:0] wreg;
    logic [7:0] flags;
    logic [3:0] bank_sel;
    logic [7:0] wreg_sh;
    logic [7:0] flags_sh;
    logic [3:0] bank_sh;
    logic gie_high;
    logic gie_low;
    logic [4:0] sp;
    logic [15:0] last_op;
    logic [11:0] eff;
    logic dest_file;
  } state_s;
  state_s s;
  state_s next_s;
  logic [20:0] stack_mem [0:31];
  logic [20:0] stack_top;
  logic push_now;
  logic [11:0] eff_addr;
  logic offset_mode;
  logic [15:0] op;
  logic do_exec;
  logic wr_go;

  assign stack_top = stack_mem[s.sp];
  assign op = s.w_data[15:0];
  assign awready = !s.aw_have && !s.b_pend;
  assign wready = !s.w_have && !s.b_pend;
  assign arready = !s.r_pend;
  assign bvalid = s.b_pend;
  assign bresp = s.b_code;
  assign rvalid = s.r_pend;
  assign rdata = s.r_data;
  assign rresp = s.r_code;
  assign wr_go = s.aw_have && s.w_have;
  assign do_exec = wr_go && s.aw_addr == stack_exec_pkg::instr_off;
  assign push_now = do_exec && op == stack_exec_pkg::op_push;

  operand_addr i_operand_addr (
    .ext_en(s.ext_en),
    .ram_sel(op[8]),
    .file_op(op[7:0]),
    .bank_sel(s.bank_sel),
    .ptr_two(s.ptr_two),
    .eff_addr(eff_addr),
    .offset_mode(offset_mode)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    next_s = s;
    if (awvalid && awready) begin
      next_s.aw_addr = awaddr;
      next_s.aw_have = 1'b1;
    end
    if (wvalid && wready) begin
      next_s.w_data = wdata;
      next_s.w_have = 1'b1;
    end
    if (bvalid && bready) begin
      next_s.b_pend = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.b_pend = 1'b1;
      next_s.b_code = 2'b00;
      unique case (s.aw_addr)
        stack_exec_pkg::ctrl_off: begin
          m = merge({19'h0, s.ptr_two, s.in_high}, s.w_data, wstrb_q());
          next_s.in_high = m[0];
          next_s.ptr_two = m[12:1];
          next_s.ext_en = s.w_data[31];
        end
        stack_exec_pkg::instr_off: begin
          next_s.last_op = op;
          if (op == stack_exec_pkg::op_push) begin
            next_s.sp = s.sp + 5'h1;
          end else if (op == stack_exec_pkg::op_pop) begin
            next_s.sp = s.sp - 5'h1;
          end else if (op[15:1] == stack_exec_pkg::op_irq_ret) begin
            next_s.pc = stack_top;
            next_s.sp = s.sp - 5'h1;
            if (s.in_high) begin
              next_s.gie_high = 1'b1;
            end else begin
              next_s.gie_low = 1'b1;
            end
            if (op[0]) begin
              next_s.wreg = s.wreg_sh;
              next_s.flags = s.flags_sh;
              next_s.bank_sel = s.bank_sh;
            end
          end else if (op[15:8] == stack_exec_pkg::op_lit_ret) begin
            next_s.wreg = op[7:0];
            next_s.pc = stack_top;
            next_s.sp = s.sp - 5'h1;
          end else begin
            next_s.eff = eff_addr;
            next_s.dest_file = op[9];
            next_s.pc = s.pc + 21'h2;
          end
        end
        stack_exec_pkg::pc_off: next_s.pc = s.w_data[20:0];
        stack_exec_pkg::wreg_off: next_s.wreg = s.w_data[7:0];
        stack_exec_pkg::stat_off: begin
          next_s.flags = s.w_data[7:0];
          next_s.bank_sel = s.w_data[11:8];
          next_s.gie_high = s.w_data[12];
          next_s.gie_low = s.w_data[13];
        end
        stack_exec_pkg::shadow_off: begin
          next_s.wreg_sh = s.w_data[7:0];
          next_s.flags_sh = s.w_data[15:8];
          next_s.bank_sh = s.w_data[19:16];
        end
        default: next_s.b_code = 2'b10;
      endcase
    end
    if (rvalid && rready) begin
      next_s.r_pend = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.r_pend = 1'b1;
      next_s.r_code = 2'b00;
      unique case (araddr)
        stack_exec_pkg::ctrl_off:
          next_s.r_data = {s.ext_en, 18'h0, s.ptr_two, s.in_high};
        stack_exec_pkg::instr_off: next_s.r_data = {16'h0, s.last_op};
        stack_exec_pkg::pc_off: next_s.r_data = {11'h0, s.pc};
        stack_exec_pkg::wreg_off: next_s.r_data = {24'h0, s.wreg};
        stack_exec_pkg::stat_off:
          next_s.r_data = {18'h0, s.gie_low, s.gie_high, s.bank_sel, s.flags};
        stack_exec_pkg::addr_off:
          next_s.r_data = {19'h0, s.dest_file, s.eff};
        stack_exec_pkg::shadow_off:
          next_s.r_data = {12'h0, s.bank_sh, s.flags_sh, s.wreg_sh};
        stack_exec_pkg::stack_off: next_s.r_data = {6'h0, s.sp, stack_top};
        default: begin
          next_s.r_data = 32'h0;
          next_s.r_code = 2'b10;
        end
      endcase
    end
  end

  function automatic logic [3:0] wstrb_q();
    return 4'hf;
  endfunction : wstrb_q

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.pc <= stack_exec_pkg::pc_reset;
    end else begin
      s <= next_s;
    end
  end

  // Stack memory has no reset; only sp defines valid depth
  always_ff @(posedge aclk) begin
    if (push_now) begin
      stack_mem[s.sp + 5'h1] <= s.pc + 21'h2;
    end
  end

  a_push_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    push_now |=> s.flags == $past(s.flags) && stack_top == $past(s.pc) + 21'h2)
    else $error("push wrong");
  a_pop_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    do_exec && op == stack_exec_pkg::op_pop |=> s.sp == $past(s.sp) - 5'h1
      && s.flags == $past(s.flags))
    else $error("pop wrong");
  a_ret_pc: assert property (@(posedge aclk) disable iff (!aresetn)
    do_exec && op[15:1] == stack_exec_pkg::op_irq_ret |=>
      s.pc == $past(stack_top))
    else $error("return pc wrong");
  a_ret_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    do_exec && op[15:1] == stack_exec_pkg::op_irq_ret |=>
      ($past(s.in_high) ? s.gie_high : s.gie_low))
    else $error("no enable set");
  a_fast_restore: assert property (@(posedge aclk) disable iff (!aresetn)
    do_exec && op == {stack_exec_pkg::op_irq_ret, 1'b1} |=>
      s.wreg == $past(s.wreg_sh) && s.bank_sel == $past(s.bank_sh))
    else $error("shadow not restored");
  a_slow_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    do_exec && op == {stack_exec_pkg::op_irq_ret, 1'b0} |=>
      s.wreg == $past(s.wreg) && s.flags == $past(s.flags))
    else $error("registers changed");
  a_lit_ret: assert property (@(posedge aclk) disable iff (!aresetn)
    do_exec && op[15:8] == stack_exec_pkg::op_lit_ret |=>
      s.wreg == $past(op[7:0]) && s.pc == $past(stack_top))
    else $error("literal return wrong");
  a_bank_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    !s.ext_en && op[8] |-> eff_addr == {s.bank_sel, op[7:0]})
    else $error("banked address wrong");
  a_offset_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    offset_mode && s.ptr_two == 12'h0 |-> eff_addr == {4'h0, op[7:0]})
    else $error("offset address wrong");
endmodule : stack_exec
`default_nettype wire

/* pkg/stack_exec_pkg.sv */
// Purpose: constants for the stack return and operand executor
// Assumes: 16-bit opcodes, 21-bit program counter
// Notes: register offsets are byte addresses on AXI4-Lite
`default_nettype none
package stack_exec_pkg;
  localparam logic [15:0] op_push = 16'h0005;
  localparam logic [15:0] op_pop = 16'h0006;
  localparam logic [14:0] op_irq_ret = 15'h0008;
  localparam logic [7:0] op_lit_ret = 8'h0c;
  localparam logic [7:0] offset_limit = 8'h5f;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] instr_off = 8'h04;
  localparam logic [7:0] pc_off = 8'h08;
  localparam logic [7:0] wreg_off = 8'h0c;
  localparam logic [7:0] stat_off = 8'h10;
  localparam logic [7:0] addr_off = 8'h14;
  localparam logic [7:0] shadow_off = 8'h18;
  localparam logic [7:0] stack_off = 8'h1c;
  localparam logic [20:0] pc_reset = 21'h000000;
  localparam int depth = 31;
endpackage : stack_exec_pkg
`default_nettype wire

/* design/operand_addr.sv */
// Purpose: effective data address of a byte or bit instruction
// Assumes: 12-bit data address space
// Notes: purely combinational
`default_nettype none
module operand_addr (
  input wire logic ext_en,
  input wire logic ram_sel,
  input wire logic [7:0] file_op,
  input wire logic [3:0] bank_sel,
  input wire logic [11:0] ptr_two,
  output logic [11:0] eff_addr,
  output logic offset_mode
);
  always_comb begin
    offset_mode = ext_en && !ram_sel && file_op <= stack_exec_pkg::offset_limit;
    if (offset_mode) begin
      eff_addr = ptr_two + {4'h0, file_op};
    end else if (ram_sel) begin
      eff_addr = {bank_sel, file_op};
    end else begin
      eff_addr = (file_op < 8'h60) ? {4'h0, file_op} : {4'hf, file_op};
    end
  end
endmodule : operand_addr
`default_nettype wire

/* verification/tb_stack_exec.sv */
// Purpose: self-checking bench for the stack return and operand executor
// Assumes: register map and opcode constants of stack_exec_pkg
// Notes: handshakes are sampled at the rising edge that takes them
`default_nettype none
module tb_stack_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] rv;
  logic [1:0] rr;
  // Control word, opcode, expected {dest, address}
  logic [31:0] tc [0:8] = '{0, 0, 0, 32'h80000240, 32'h80000240,
    32'h80000240, 32'h80000240, 32'h80000000, 32'h80000240};
  logic [15:0] ti [0:8] = '{16'h2445, 16'h24a0, 16'h2545, 16'h2445,
    16'h245f, 16'h2460, 16'h2645, 16'h2445, 16'h2545};
  logic [31:0] te [0:8] = '{32'h045, 32'hfa0, 32'h345, 32'h165,
    32'h17f, 32'hf60, 32'h1165, 32'h045, 32'h345};

  always #4 aclk = ~aclk;

  stack_exec i_stack_exec (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic final_report();
    $display("mismatches %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ready stays high after a response, so no strobe toggles in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      tb = bvalid;
      rr = bresp;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      tr = rvalid;
      rv = rdata;
      rr = rresp;
    end
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    rd(a);
    chk(rv & m, e);
  endtask : rdc

  task automatic ex(input logic [15:0] op);
    wr(stack_exec_pkg::instr_off, {16'h0000, op});
  endtask : ex

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(stack_exec_pkg::stat_off, 32'h00000300);
    for (int i = 0; i < 9; i++) begin
      wr(stack_exec_pkg::ctrl_off, tc[i]);
      ex(ti[i]);
      rdc(stack_exec_pkg::addr_off, 32'h1fff, te[i]);
    end
    wr(stack_exec_pkg::stat_off, 32'h0000005a);
    wr(stack_exec_pkg::pc_off, 32'h124);
    ex(stack_exec_pkg::op_push);
    rdc(stack_exec_pkg::stack_off, 32'h1fffff, 32'h126);
    rdc(stack_exec_pkg::stat_off, 32'hffffffff, 32'h5a);
    wr(stack_exec_pkg::pc_off, 32'h300);
    ex(stack_exec_pkg::op_push);
    rdc(stack_exec_pkg::stack_off, 32'h1fffff, 32'h302);
    ex(stack_exec_pkg::op_pop);
    rdc(stack_exec_pkg::stack_off, 32'h1fffff, 32'h126);
    rdc(stack_exec_pkg::stat_off, 32'hffffffff, 32'h5a);
    ex({stack_exec_pkg::op_lit_ret, 8'h77});
    rdc(stack_exec_pkg::wreg_off, 32'hff, 32'h77);
    rdc(stack_exec_pkg::pc_off, 32'h1fffff, 32'h126);
    // Entry zero was never written, so only the depth is compared
    rdc(stack_exec_pkg::stack_off, 32'h3e00000, 32'h0);
    wr(stack_exec_pkg::pc_off, 32'h400);
    ex(stack_exec_pkg::op_push);
    wr(stack_exec_pkg::wreg_off, 32'h11);
    wr(stack_exec_pkg::stat_off, 32'h22);
    wr(stack_exec_pkg::shadow_off, 32'h00053344);
    wr(stack_exec_pkg::ctrl_off, 32'h1);
    ex({stack_exec_pkg::op_irq_ret, 1'b0});
    rdc(stack_exec_pkg::pc_off, 32'h1fffff, 32'h402);
    rdc(stack_exec_pkg::wreg_off, 32'hff, 32'h11);
    rdc(stack_exec_pkg::stat_off, 32'h3fff, 32'h1022);
    wr(stack_exec_pkg::pc_off, 32'h500);
    ex(stack_exec_pkg::op_push);
    wr(stack_exec_pkg::ctrl_off, 32'h0);
    ex({stack_exec_pkg::op_irq_ret, 1'b1});
    rdc(stack_exec_pkg::pc_off, 32'h1fffff, 32'h502);
    rdc(stack_exec_pkg::wreg_off, 32'hff, 32'h44);
    rdc(stack_exec_pkg::stat_off, 32'h2fff, 32'h2533);
    // Unmapped places answer with a slave error and zero data
    rd(8'h20);
    chk({30'h0, rr}, 32'h2);
    chk(rv, 32'h0);
    wr(8'h24, 32'h12345678);
    chk({30'h0, rr}, 32'h2);
    final_report();
  end
endmodule : tb_stack_exec
`default_nettype wire
